// ---- rtl/ppio_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk_i,
   input  wire logic             clr_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // =====================================================
   // storage and pointers
   // =====================================================
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    rptr_q;
   logic [AW:0]      count_q;

   wire push = in_valid_i & in_ready_o;
   wire pop  = out_valid_o & out_ready_i;

   assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rptr_q];

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end else if (clr_i) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ---- rtl/ppio_pkg.sv ----
// Operation
// - control port stores byte inverted, pins show true
// - control port drivers float when enable low
// - control port register survives every reset
// - connector reset resets processor only
// - input latches transparent on gate high, hold
// - input read loads byte, read pulse low
// - output write loads latch, then data-valid low
// - data stable before data-valid rising edge
// - resets clear both general output latches
// - memory-disable option makes bit seven memory control
// - wait line low holds processor in wait
// - control input port read live, unlatched
// - interrupt line falling edge sets interrupt bit
`default_nettype none
package ppio_pkg;
   // port addresses on the processor I/O bus
   localparam logic [7:0] ADDR_CTL   = 8'h04;
   localparam logic [7:0] ADDR_PORTA = 8'h0A;
   localparam logic [7:0] ADDR_PORTB = 8'h0B;
   // widths
   localparam int DATA_W = 8;
   localparam int MSB    = 7;
   localparam int FIFO_DEPTH = 4;
   // reset values
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [7:0] RD_RST  = 8'h00;
   // timing: data-valid pulse length, one processor write cycle
   localparam int CLK_PERIOD_NS  = 25;
   localparam int DV_PULSE_NS    = 25;
   localparam int DV_PULSE_CYC_I = (DV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DV_PULSE_CYC   = (DV_PULSE_CYC_I < 1) ? 1 : DV_PULSE_CYC_I;
   localparam int DV_CNT_W = 4;
   // synchroniser bit layout
   localparam int SY_W = 32;
   localparam logic [31:0] SY_RST = 32'hFFFF_FFFF;
   // output stage states, gray from idle to recover
   typedef enum logic [1:0] {
      OS_IDLE    = 2'b00,
      OS_STROBE  = 2'b01,
      OS_RECOVER = 2'b11
   } ppio_ostate_e;
endpackage
`default_nettype wire

// ---- rtl/ppio_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_sync #(
   parameter int          WIDTH   = 8,
   parameter logic [31:0] RST_VAL = 32'h0
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   // =====================================================
   // two-flop synchroniser
   // =====================================================
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL[WIDTH-1:0];
         sync_q <= RST_VAL[WIDTH-1:0];
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

// ---- rtl/ppio_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_top #(
   parameter int DATA_W     = ppio_pkg::DATA_W,
   parameter int FIFO_DEPTH = ppio_pkg::FIFO_DEPTH
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              power_on_clear_i,
   // processor I/O bus
   input  wire logic [7:0]        io_addr_i,
   input  wire logic              io_wr_i,
   input  wire logic              io_rd_i,
   input  wire logic [DATA_W-1:0] io_wdata_i,
   output logic      [DATA_W-1:0] io_rdata_o,
   output logic                   io_rdata_valid_o,
   output logic                   io_wait_o,
   output logic                   cpu_reset_o,
   // controller port connector
   input  wire logic [DATA_W-1:0] ctl_in_i,
   output logic      [DATA_W-1:0] ctl_out_o,
   output logic                   ctl_out_oe_n_o,
   input  wire logic              ctl_out_enable_i,
   input  wire logic              ctl_reset_n_i,
   input  wire logic              ctl_int_n_i,
   output logic                   ctl_int_flag_o,
   input  wire logic              ctl_int_clr_i,
   // general port A connector
   input  wire logic [DATA_W-1:0] pa_in_i,
   input  wire logic              pa_gate_i,
   output logic                   pa_port_read_pulse_n_o,
   output logic      [DATA_W-1:0] pa_out_o,
   output logic                   pa_data_valid_n_o,
   input  wire logic              pa_wait_n_i,
   // general port B connector
   input  wire logic [DATA_W-1:0] pb_in_i,
   input  wire logic              pb_gate_i,
   output logic                   pb_port_read_pulse_n_o,
   output logic      [DATA_W-1:0] pb_out_o,
   output logic                   pb_data_valid_n_o,
   input  wire logic              pb_wait_n_i,
   // memory-disable option
   input  wire logic              mem_disable_sel_i,
   output logic                   onboard_mem_off_o
);
   // =====================================================
   // pin synchronisation
   // =====================================================
   logic [ppio_pkg::SY_W-1:0] sy_raw;
   logic [ppio_pkg::SY_W-1:0] sy;

   assign sy_raw = {ctl_in_i, pa_in_i, pb_in_i, pa_gate_i, pb_gate_i,
                    ctl_out_enable_i, ctl_reset_n_i, ctl_int_n_i,
                    pa_wait_n_i, pb_wait_n_i, ~mem_disable_sel_i};

   ppio_sync #(
      .WIDTH   (ppio_pkg::SY_W),
      .RST_VAL (ppio_pkg::SY_RST)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .async_i   (sy_raw),
      .sync_o    (sy)
   );

   wire [7:0] ctl_in_s  = sy[31:24];
   wire [7:0] pa_in_s   = sy[23:16];
   wire [7:0] pb_in_s   = sy[15:8];
   wire       pa_gate_s = sy[7];
   wire       pb_gate_s = sy[6];
   wire       ctl_oe_s  = sy[5];
   wire       ctl_rst_n = sy[4];
   wire       ctl_int_s = sy[3];
   wire       pa_wait_s = sy[2];
   wire       pb_wait_s = sy[1];
   wire       mem_sel_s = ~sy[0];

   // =====================================================
   // address decode
   // =====================================================
   wire sel_ctl = (io_addr_i == ppio_pkg::ADDR_CTL);
   wire sel_pa  = (io_addr_i == ppio_pkg::ADDR_PORTA);
   wire sel_pb  = (io_addr_i == ppio_pkg::ADDR_PORTB);

   wire ext_wait  = ~pa_wait_s | ~pb_wait_s;
   wire fifo_in_ready;
   wire gen_wr    = io_wr_i & (sel_pa | sel_pb);
   wire wr_stall  = gen_wr & ~fifo_in_ready;
   wire wr_ctl    = io_wr_i & sel_ctl & ~io_wait_o;
   wire wr_gen    = gen_wr & ~io_wait_o;
   wire rd_take   = io_rd_i & ~io_wait_o;

   // processor held while either connector wait line is low
   assign io_wait_o = ext_wait | wr_stall;

   // connector reset reaches the processor only
   assign cpu_reset_o = rst_i | ~ctl_rst_n;

   // =====================================================
   // controller output port
   // =====================================================
   // no reset: contents survive bus reset and power-on clear
   logic [DATA_W-1:0] ctl_out_inv_q;

   always_ff @(posedge sys_clk_i) begin
      if (wr_ctl) begin
         ctl_out_inv_q <= ~io_wdata_i;
      end
   end

   // inverting drivers restore polarity
   assign ctl_out_o      = ~ctl_out_inv_q;
   assign ctl_out_oe_n_o = ~ctl_oe_s;

   // =====================================================
   // controller interrupt line
   // =====================================================
   logic ctl_int_prev_q;
   logic ctl_int_flag_q;
   wire  ctl_int_fall = ctl_int_prev_q & ~ctl_int_s;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_int_prev_q <= 1'b1;
         ctl_int_flag_q <= 1'b0;
      end else begin
         ctl_int_prev_q <= ctl_int_s;
         // a new edge wins over a clear in the same cycle
         if (ctl_int_fall) begin
            ctl_int_flag_q <= 1'b1;
         end else if (ctl_int_clr_i) begin
            ctl_int_flag_q <= 1'b0;
         end
      end
   end

   assign ctl_int_flag_o = ctl_int_flag_q;

   // =====================================================
   // general input latches
   // =====================================================
   logic [DATA_W-1:0] pa_latch_q;
   logic [DATA_W-1:0] pb_latch_q;

   // transparent while gate high, holds value from falling edge
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pa_latch_q <= ppio_pkg::RD_RST;
         pb_latch_q <= ppio_pkg::RD_RST;
      end else begin
         if (pa_gate_s) begin
            pa_latch_q <= pa_in_s;
         end
         if (pb_gate_s) begin
            pb_latch_q <= pb_in_s;
         end
      end
   end

   // read pulse low for the whole read cycle addressing the port
   assign pa_port_read_pulse_n_o = ~(io_rd_i & sel_pa);
   assign pb_port_read_pulse_n_o = ~(io_rd_i & sel_pb);

   // =====================================================
   // read data
   // =====================================================
   wire [DATA_W-1:0] rd_mux = sel_pa  ? pa_latch_q :
                              sel_pb  ? pb_latch_q :
                              sel_ctl ? ctl_in_s :
                              ppio_pkg::RD_RST;

   logic [DATA_W-1:0] rdata_q;
   logic              rvalid_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q  <= ppio_pkg::RD_RST;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_take;
         if (rd_take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign io_rdata_o       = rdata_q;
   assign io_rdata_valid_o = rvalid_q;

   // =====================================================
   // general output path: write buffer
   // =====================================================
   wire              out_clr = power_on_clear_i;
   wire              q_valid;
   logic             q_ready;
   wire [DATA_W:0]   q_data;

   ppio_fifo #(
      .WIDTH (DATA_W + 1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .clr_i       (out_clr),
      .rst_i       (rst_i),
      .in_valid_i  (wr_gen),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({sel_pb, io_wdata_i}),
      .out_valid_o (q_valid),
      .out_ready_i (q_ready),
      .out_data_o  (q_data)
   );

   // =====================================================
   // general output stage
   // =====================================================
   ppio_pkg::ppio_ostate_e os_q;
   ppio_pkg::ppio_ostate_e os_d;
   logic [ppio_pkg::DV_CNT_W-1:0] dv_cnt_q;
   logic [DATA_W-1:0] pa_out_q;
   logic [DATA_W-1:0] pb_out_q;
   logic              dv_port_q;

   wire dv_done = (dv_cnt_q == ppio_pkg::DV_CNT_W'(ppio_pkg::DV_PULSE_CYC - 1));

   // a new entry is not started while a slow device holds wait
   always_comb begin
      os_d    = os_q;
      q_ready = 1'b0;
      case (os_q)
         ppio_pkg::OS_IDLE: begin
            if (q_valid && !ext_wait) begin
               q_ready = 1'b1;
               os_d    = ppio_pkg::OS_STROBE;
            end
         end
         ppio_pkg::OS_STROBE: begin
            if (dv_done) begin
               os_d = ppio_pkg::OS_RECOVER;
            end
         end
         ppio_pkg::OS_RECOVER: begin
            os_d = ppio_pkg::OS_IDLE;
         end
         default: begin
            os_d = ppio_pkg::OS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         os_q     <= ppio_pkg::OS_IDLE;
         dv_cnt_q <= '0;
      end else if (out_clr) begin
         os_q     <= ppio_pkg::OS_IDLE;
         dv_cnt_q <= '0;
      end else begin
         os_q     <= os_d;
         dv_cnt_q <= (os_q == ppio_pkg::OS_STROBE) ? dv_cnt_q + 1'b1 : '0;
      end
   end

   // latch loaded on the edge the pulse starts, so data is steady through the pulse
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pa_out_q  <= ppio_pkg::OUT_RST;
         pb_out_q  <= ppio_pkg::OUT_RST;
         dv_port_q <= 1'b0;
      end else if (out_clr) begin
         pa_out_q  <= ppio_pkg::OUT_RST;
         pb_out_q  <= ppio_pkg::OUT_RST;
         dv_port_q <= 1'b0;
      end else if (q_ready) begin
         dv_port_q <= q_data[DATA_W];
         if (q_data[DATA_W]) begin
            pb_out_q <= q_data[DATA_W-1:0];
         end else begin
            pa_out_q <= q_data[DATA_W-1:0];
         end
      end
   end

   wire dv_active = (os_q == ppio_pkg::OS_STROBE);

   assign pa_out_o          = pa_out_q;
   assign pb_out_o          = pb_out_q;
   assign pa_data_valid_n_o = ~(dv_active & ~dv_port_q);
   assign pb_data_valid_n_o = ~(dv_active & dv_port_q);

   // bit seven becomes memory control under the option
   assign onboard_mem_off_o = mem_sel_s & pa_out_q[ppio_pkg::MSB];
endmodule
`default_nettype wire

// ---- tb/ppio_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_chk (
   input wire logic       sys_clk_i,
   input wire logic       rst_i,
   input wire logic       power_on_clear_i,
   input wire logic [7:0] io_addr_i,
   input wire logic       io_wr_i,
   input wire logic       io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic       io_rdata_valid_o,
   input wire logic       io_wait_o,
   input wire logic [7:0] ctl_in_i,
   input wire logic [7:0] ctl_out_o,
   input wire logic       ctl_out_oe_n_o,
   input wire logic       ctl_out_enable_i,
   input wire logic       ctl_int_n_i,
   input wire logic       ctl_int_flag_o,
   input wire logic       pa_port_read_pulse_n_o,
   input wire logic       pb_port_read_pulse_n_o,
   input wire logic [7:0] pa_out_o,
   input wire logic       pa_data_valid_n_o,
   input wire logic       pa_wait_n_i
);
   // =====
   // requests: rd_go and wr_ctl when taken, rd_a and rd_b raw
   wire logic rd_go  = io_rd_i && !io_wait_o;
   wire logic wr_ctl = io_wr_i && !io_wait_o && io_addr_i == ppio_pkg::ADDR_CTL;
   wire logic rd_a   = io_rd_i && io_addr_i == ppio_pkg::ADDR_PORTA;
   wire logic rd_b   = io_rd_i && io_addr_i == ppio_pkg::ADDR_PORTB;
   logic      seen_q;
   // marks that the control register holds a written byte
   always_ff @(posedge sys_clk_i) begin
      if (wr_ctl) begin
         seen_q <= 1'b1;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_dv_fall;
      $fell(pa_data_valid_n_o);
   endsequence
   sequence s_dv_rise;
      $rose(pa_data_valid_n_o) && $stable(pa_out_o);
   endsequence
   // =====
   // properties
   chk_ctl_store: assert property (wr_ctl |=> ctl_out_o == $past(io_wdata_i))
      else $error("control byte wrong");
   chk_oe_follow: assert property ((ctl_out_enable_i[*4] |-> !ctl_out_oe_n_o) and
      (!ctl_out_enable_i[*4] |-> ctl_out_oe_n_o)) else $error("output enable wrong");
   chk_ctl_keep: assert property (disable iff (1'b0)
      seen_q && (rst_i || power_on_clear_i) && !io_wr_i |=> $stable(ctl_out_o))
      else $error("control byte lost on reset");
   chk_out_clear: assert property (disable iff (1'b0)
      rst_i || power_on_clear_i |=> pa_out_o == 8'h00) else $error("port a not cleared");
   chk_rd_pulse: assert property (pa_port_read_pulse_n_o == !rd_a)
      else $error("read pulse wrong");
   chk_rd_pulse_b: assert property (pb_port_read_pulse_n_o == !rd_b)
      else $error("port b read pulse wrong");
   chk_rd_answer: assert property ((rd_go |=> io_rdata_valid_o) and
      (io_rdata_valid_o |-> $past(rd_go))) else $error("read answer wrong");
   chk_live_read: assert property (($stable(ctl_in_i)[*4] ##0
      (rd_go && io_addr_i == ppio_pkg::ADDR_CTL)) |=> io_rdata_o == $past(ctl_in_i))
      else $error("control input not live");
   chk_dv_pulse: assert property (s_dv_fall |=> s_dv_rise)
      else $error("data valid pulse wrong");
   chk_wait_hold: assert property (!pa_wait_n_i[*4] |-> io_wait_o && pa_data_valid_n_o)
      else $error("wait not honoured");
   chk_int_edge: assert property ($fell(ctl_int_n_i) |-> ##[2:5] ctl_int_flag_o)
      else $error("interrupt flag not set");
endmodule
bind ppio_top ppio_chk u_chk (.*);
`default_nettype wire

// ---- tb/ppio_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_dev (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] a_byte_i,
   input  wire logic       hold_i,
   input  wire logic       slow_i,
   input  wire logic [3:0] strb_i,
   output logic            gate_o,
   output logic            pa_wait_n_o,
   output logic            pb_wait_n_o,
   output logic            int_n_o
);
   // strb_i: pb read, pb valid, pa read, pa valid, all active low
   logic [2:0] wa_q   = 3'h0;
   logic [2:0] wb_q   = 3'h0;
   logic [2:0] ia_q   = 3'h0;
   logic [3:0] last_q = 4'hF;
   logic [7:0] seen_q = 8'h00;
   // trailing edge of valid or leading edge of read starts a wait stretch
   wire logic  pace_a = slow_i && ((strb_i[0] && !last_q[0]) ||
                                   (!strb_i[1] && last_q[1]));
   wire logic  pace_b = slow_i && ((strb_i[2] && !last_q[2]) ||
                                   (!strb_i[3] && last_q[3]));
   always_ff @(posedge sys_clk_i) begin
      last_q <= strb_i;
      seen_q <= a_byte_i;
      wa_q   <= pace_a ? 3'h5 : ((wa_q != 3'h0) ? wa_q - 3'h1 : 3'h0);
      wb_q   <= pace_b ? 3'h5 : ((wb_q != 3'h0) ? wb_q - 3'h1 : 3'h0);
      ia_q   <= (a_byte_i != seen_q) ? 3'h4 : ((ia_q != 3'h0) ? ia_q - 3'h1 : 3'h0);
   end
   assign gate_o      = !hold_i;
   assign pa_wait_n_o = (wa_q == 3'h0);
   assign pb_wait_n_o = (wb_q == 3'h0);
   assign int_n_o     = (ia_q == 3'h0);
endmodule
`default_nettype wire

// ---- tb/ppio_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppio_top_tb;
   logic            sys_clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            power_on_clear_i = 1'b0;
   logic            io_wr_i = 1'b0;
   logic            io_rd_i = 1'b0;
   logic            ctl_out_enable_i = 1'b1;
   logic            ctl_reset_n_i = 1'b1;
   logic            ctl_int_clr_i = 1'b0;
   logic            mem_disable_sel_i = 1'b0;
   logic            hold = 1'b0;
   logic            slow = 1'b0;
   logic [7:0]      io_addr_i = 8'h00;
   logic [7:0]      io_wdata_i = 8'h00;
   logic [7:0]      ctl_in_i = 8'h00;
   logic [7:0]      pa_in_i = 8'h00;
   logic [7:0]      pb_in_i = 8'h00;
   wire logic [7:0] io_rdata_o, ctl_out_o, pa_out_o, pb_out_o;
   wire logic       pa_gate_i, pa_wait_n_i, pb_wait_n_i, ctl_int_n_i, io_rdata_valid_o;
   wire logic       io_wait_o, cpu_reset_o, ctl_out_oe_n_o, ctl_int_flag_o, onboard_mem_off_o;
   wire logic       pa_port_read_pulse_n_o, pb_port_read_pulse_n_o;
   wire logic       pa_data_valid_n_o, pb_data_valid_n_o;
   wire logic       pb_gate_i = pa_gate_i;
   logic [7:0]      rq[$];
   logic [8:0]      wq[$];
   int              err_count = 0;
   int              checks_done = 0;
   int              waited = 0;
   always #12.5 sys_clk_i = ~sys_clk_i;
   ppio_top uut (.*);
   ppio_dev dev (.sys_clk_i(sys_clk_i), .a_byte_i(pa_in_i), .hold_i(hold), .slow_i(slow),
      .strb_i({pb_port_read_pulse_n_o, pb_data_valid_n_o, pa_port_read_pulse_n_o,
      pa_data_valid_n_o}), .gate_o(pa_gate_i), .pa_wait_n_o(pa_wait_n_i),
      .pb_wait_n_o(pb_wait_n_i), .int_n_o(ctl_int_n_i));
   // =====
   // tasks
   task automatic test_done();
      // every noted read or write must have been answered
      cmp(16'(rq.size() + wq.size()), 16'h0000);
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // request stays up after the take so a caller may go back to back
   task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int   n;
      logic stall;
      io_wr_i = wr;
      io_rd_i = !wr;
      io_addr_i = a;
      io_wdata_i = d;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         stall = io_wait_o;
         n++;
         @(posedge sys_clk_i);
      end while (stall !== 1'b0 && n < 300);
      if (stall !== 1'b0) begin
         err_count++;
         test_done();
      end
      waited += n - 1;
      if (!wr) begin
         rq.push_back(d);
      end else if (a == ppio_pkg::ADDR_PORTA || a == ppio_pkg::ADDR_PORTB) begin
         wq.push_back({a[0], d});
      end
      #1;
   endtask
   task automatic drain();
      int n;
      io_wr_i = 1'b0;
      io_rd_i = 1'b0;
      for (n = 0; n < 500 && (wq.size() != 0 || io_wait_o !== 1'b0); n++) begin
         @(posedge sys_clk_i);
      end
      if (n == 500) begin
         err_count++;
         test_done();
      end
      cyc(8);
   endtask
   // =====
   // result monitor
   always @(posedge sys_clk_i) begin
      #2;
      if (io_rdata_valid_o === 1'b1) begin
         cmp({8'h00, io_rdata_o}, rq.size() ? {8'h00, rq.pop_front()} : 16'hFFFF);
      end
      if (pa_data_valid_n_o === 1'b0) begin
         cmp({8'h00, pa_out_o}, wq.size() ? {7'h00, wq.pop_front()} : 16'hFFFF);
      end
      if (pb_data_valid_n_o === 1'b0) begin
         cmp({8'h01, pb_out_o}, wq.size() ? {7'h00, wq.pop_front()} : 16'hFFFF);
      end
   end
   // =====
   // main sequence
   initial begin
      logic [7:0] r, s, t;
      int         k;
      void'($urandom(50990));
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      cyc(2);
      cmp({pa_data_valid_n_o, pb_data_valid_n_o, 6'h00, pa_out_o | pb_out_o}, 16'hC000);
      $display("test reset done");
      r = 8'($urandom);
      io(1'b1, ppio_pkg::ADDR_CTL, r);
      cmp({8'h00, ctl_out_o}, {8'h00, r});
      for (k = 0; k < 2; k++) begin
         io(1'b1, ppio_pkg::ADDR_PORTA, 8'($urandom) | 8'h01);
         io(1'b1, ppio_pkg::ADDR_PORTB, 8'($urandom) | 8'h01);
         drain();
         power_on_clear_i = (k == 0);
         rst_i = (k == 1);
         cyc(1);
         power_on_clear_i = 1'b0;
         rst_i = 1'b0;
         cyc(3);
         cmp({pa_out_o | pb_out_o, ctl_out_o}, {8'h00, r});
      end
      for (k = 0; k < 2; k++) begin
         ctl_out_enable_i = k[0];
         cyc(5);
         cmp({15'h0, ctl_out_oe_n_o}, {15'h0, !k[0]});
      end
      $display("test control port done");
      for (k = 0; k < 2; k++) begin
         s = pa_in_i;
         t = pb_in_i;
         hold = k[0];
         cyc(1);
         pa_in_i = pa_in_i ^ (8'($urandom) | 8'h01);
         pb_in_i = pb_in_i ^ (8'($urandom) | 8'h01);
         cyc(4);
         io(1'b0, ppio_pkg::ADDR_PORTA, k[0] ? s : pa_in_i);
         io(1'b0, ppio_pkg::ADDR_PORTB, k[0] ? t : pb_in_i);
         drain();
      end
      hold = 1'b0;
      cmp({15'h0, ctl_int_flag_o}, 16'h1);
      ctl_int_clr_i = 1'b1;
      cyc(1);
      ctl_int_clr_i = 1'b0;
      cmp({15'h0, ctl_int_flag_o}, 16'h0);
      ctl_in_i = 8'($urandom);
      cyc(4);
      io(1'b0, ppio_pkg::ADDR_CTL, ctl_in_i);
      io(1'b0, 8'h05, 8'h00);
      io(1'b1, 8'h05, 8'($urandom));
      drain();
      $display("test input ports done");
      slow = 1'b1;
      for (k = 0; k < 8; k++) begin
         io(1'b1, k[0] ? ppio_pkg::ADDR_PORTB : ppio_pkg::ADDR_PORTA, 8'($urandom));
      end
      io(1'b0, ppio_pkg::ADDR_PORTB, pb_in_i);
      drain();
      cmp({15'h0, waited != 0}, 16'h1);
      slow = 1'b0;
      $display("test paced output done");
      for (k = 0; k < 2; k++) begin
         mem_disable_sel_i = k[0];
         r = 8'h80 | 8'($urandom);
         io(1'b1, ppio_pkg::ADDR_PORTA, r);
         drain();
         cmp({15'h0, onboard_mem_off_o}, {15'h0, k[0]});
      end
      ctl_reset_n_i = 1'b0;
      cyc(5);
      cmp({7'h0, cpu_reset_o, pa_out_o}, {7'h0, 1'b1, r});
      ctl_reset_n_i = 1'b1;
      cyc(5);
      cmp({15'h0, cpu_reset_o}, 16'h0);
      $display("test options done");
      test_done();
   end
endmodule
`default_nettype wire
